//--- rtl/cgcs_pkg.sv
// constants for the clock generator control and status byte bank
package cgcs_pkg;
    // --------------------------------------------------------------
    // byte addresses
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_OUTPUT_CONTROL = 8'h03;
    localparam logic [7:0] ADDR_CPU_DIVIDER_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CPU_DIVIDER_LOW = 8'h05;
    localparam logic [7:0] ADDR_RESERVED_SIX = 8'h06;
    localparam logic [7:0] ADDR_RESERVED_SEVEN = 8'h07;
    localparam logic [7:0] ADDR_RESERVED_EIGHT = 8'h08;
    localparam logic [7:0] ADDR_PANEL_DIVIDER_READBACK = 8'h09;
    localparam logic [7:0] ADDR_STRAP_AND_REQUEST_STATUS = 8'h0a;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int REF_ENABLE_BIT = 5;
    localparam int EDGE_RATE_LSB = 3;
    localparam int EDGE_RATE_MSB = 4;
    localparam int STOP_SEL_MSB = 2;
    localparam int PROC_DIV_MSB_BIT = 0;
    localparam int PANEL_DIV_BIT7_POS = 7;
    localparam int STRAP_B_BIT = 7;
    localparam int STRAP_C_BIT = 6;
    localparam int REQ_LSB = 3;
    localparam int REQ_MSB = 5;
    // --------------------------------------------------------------
    // reset and fixed read values
    // --------------------------------------------------------------
    localparam logic REF_ENABLE_RST = 1'b1;
    localparam logic [1:0] EDGE_RATE_RST = 2'h2;
    localparam logic [1:0] EDGE_RATE_RESERVED = 2'h3;
    localparam logic [2:0] STOP_SEL_RST = 3'h0;
    localparam logic [2:0] PROC_EN_RST = 3'h7;
    // low divider reset depends on straps in silicon; plain default here
    localparam logic [8:0] PROC_DIV_RST = 9'h000;
    localparam logic [6:0] DIV_HIGH_RSVD = 7'h7f;
    localparam logic [7:0] RESERVED_SIX_VAL = 8'hc3;
    localparam logic [7:0] RESERVED_SEVEN_VAL = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // idle pin levels: request and halt pins are pulled up
    localparam logic [3:0] PIN_ACTIVE_LOW_RST = 4'hf;
    localparam logic [1:0] STRAP_PIN_RST = 2'h0;
    // --------------------------------------------------------------
    // strap capture timing
    // --------------------------------------------------------------
    localparam logic [2:0] STRAP_FILL_CYCLES = 3'h5;
    typedef enum logic [1:0] {
        ST_FILL = 2'b01,
        ST_HOLD = 2'b10
    } cgcs_strap_e;
endpackage

//--- rtl/cgcs_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cgcs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;

    // a bit only moves once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_out[i];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            level_out <= RST_VAL;
        end
        else if (ce_in)
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_out <= level_d;
        end
    end
endmodule
`default_nettype wire

//--- rtl/cgcs_regs.sv
// control and status bytes 3 to 10 of the clock generator
`timescale 1ns/1ps
`default_nettype none
module cgcs_regs (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic proc_clock_halt_n_in,
    input wire logic clock_request_0_n_in,
    input wire logic clock_request_1_n_in,
    input wire logic clock_request_2_n_in,
    input wire logic freq_select_b_in,
    input wire logic freq_select_c_in,
    input wire logic [8:0] panel_divider_in,
    output logic ref_enable_out,
    output logic [1:0] ref_edge_rate_out,
    output logic [2:0] proc_out_enable_out,
    output logic [8:0] proc_divider_out
);
    import cgcs_pkg::*;

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [3:0] act_low_s;
    logic [1:0] strap_s;
    logic halt_n_s;
    logic [2:0] req_s;

    cgcs_sync #(.WIDTH(4), .RST_VAL(PIN_ACTIVE_LOW_RST)) u_sync_req (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .pin_in({proc_clock_halt_n_in, clock_request_2_n_in,
                 clock_request_1_n_in, clock_request_0_n_in}),
        .level_out(act_low_s)
    );

    cgcs_sync #(.WIDTH(2), .RST_VAL(STRAP_PIN_RST)) u_sync_strap (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .pin_in({freq_select_b_in, freq_select_c_in}),
        .level_out(strap_s)
    );

    assign halt_n_s = act_low_s[3];
    assign req_s = act_low_s[2:0];

    // --------------------------------------------------------------
    // strap capture
    // --------------------------------------------------------------
    cgcs_strap_e strap_st_q;
    cgcs_strap_e strap_st_d;
    logic [2:0] fill_cnt_q;
    logic [2:0] fill_cnt_d;
    logic [1:0] strap_q;
    logic [1:0] strap_d;

    // wait for the synchroniser to fill, then freeze the straps for good
    always_comb
    begin
        strap_st_d = strap_st_q;
        fill_cnt_d = fill_cnt_q;
        strap_d = strap_q;
        case (strap_st_q)
            ST_FILL:
            begin
                fill_cnt_d = fill_cnt_q + 3'h1;
                if (fill_cnt_q == STRAP_FILL_CYCLES)
                begin
                    strap_d = strap_s;
                    strap_st_d = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                strap_st_d = ST_HOLD;
            end
            default:
            begin
                strap_st_d = ST_FILL;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            strap_st_q <= ST_FILL;
            fill_cnt_q <= 3'h0;
            strap_q <= STRAP_PIN_RST;
        end
        else if (ce_in)
        begin
            strap_st_q <= strap_st_d;
            fill_cnt_q <= fill_cnt_d;
            strap_q <= strap_d;
        end
    end

    // --------------------------------------------------------------
    // writable bytes and clock controls
    // --------------------------------------------------------------
    logic [2:0] stop_sel_q;
    logic [2:0] stop_sel_d;
    logic ref_enable_d;
    logic [1:0] ref_edge_rate_d;
    logic [8:0] proc_divider_d;
    logic [2:0] proc_out_enable_d;

    always_comb
    begin
        ref_enable_d = ref_enable_out;
        ref_edge_rate_d = ref_edge_rate_out;
        stop_sel_d = stop_sel_q;
        proc_divider_d = proc_divider_out;
        // writes elsewhere, incl. reserved bytes 6..8, are dropped
        if (wr_en_in && addr_in == ADDR_OUTPUT_CONTROL)
        begin
            ref_enable_d = wr_data_in[REF_ENABLE_BIT];
            // reserved code 11 is stored as written; host must avoid it
            ref_edge_rate_d = wr_data_in[EDGE_RATE_MSB:EDGE_RATE_LSB];
            stop_sel_d = wr_data_in[STOP_SEL_MSB:0];
        end
        else if (wr_en_in && addr_in == ADDR_CPU_DIVIDER_HIGH)
        begin
            proc_divider_d[8] = wr_data_in[PROC_DIV_MSB_BIT];
        end
        else if (wr_en_in && addr_in == ADDR_CPU_DIVIDER_LOW)
        begin
            proc_divider_d[7:0] = wr_data_in;
        end
        // stoppable outputs drop while halt is low; byte bit 2 steers clock 0
        proc_out_enable_d = ~({stop_sel_q[0], stop_sel_q[1], stop_sel_q[2]}
                              & {3{~halt_n_s}});
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ref_enable_out <= REF_ENABLE_RST;
            ref_edge_rate_out <= EDGE_RATE_RST;
            stop_sel_q <= STOP_SEL_RST;
            proc_divider_out <= PROC_DIV_RST;
            proc_out_enable_out <= PROC_EN_RST;
        end
        else if (ce_in)
        begin
            ref_enable_out <= ref_enable_d;
            ref_edge_rate_out <= ref_edge_rate_d;
            stop_sel_q <= stop_sel_d;
            proc_divider_out <= proc_divider_d;
            proc_out_enable_out <= proc_out_enable_d;
        end
    end

    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    logic [7:0] rd_data_d;
    logic rd_valid_d;

    always_comb
    begin
        rd_valid_d = rd_en_in;
        rd_data_d = READ_ZERO;
        if (!rd_en_in)
        begin
            rd_data_d = READ_ZERO;
        end
        else if (addr_in == ADDR_OUTPUT_CONTROL)
        begin
            rd_data_d = {2'h0, ref_enable_out, ref_edge_rate_out, stop_sel_q};
        end
        else if (addr_in == ADDR_CPU_DIVIDER_HIGH)
        begin
            rd_data_d = {DIV_HIGH_RSVD, proc_divider_out[8]};
        end
        else if (addr_in == ADDR_CPU_DIVIDER_LOW)
        begin
            rd_data_d = proc_divider_out[7:0];
        end
        else if (addr_in == ADDR_RESERVED_SIX)
        begin
            rd_data_d = RESERVED_SIX_VAL;
        end
        else if (addr_in == ADDR_RESERVED_SEVEN)
        begin
            rd_data_d = RESERVED_SEVEN_VAL;
        end
        else if (addr_in == ADDR_RESERVED_EIGHT)
        begin
            rd_data_d = READ_ZERO;
            rd_data_d[PANEL_DIV_BIT7_POS] = panel_divider_in[8];
        end
        else if (addr_in == ADDR_PANEL_DIVIDER_READBACK)
        begin
            rd_data_d = panel_divider_in[7:0];
        end
        else if (addr_in == ADDR_STRAP_AND_REQUEST_STATUS)
        begin
            // request 0 sits in status bit 5, request 2 in bit 3
            rd_data_d = {strap_q, req_s[0], req_s[1], req_s[2], 3'h0};
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rd_data_out <= READ_ZERO;
            rd_valid_out <= 1'b0;
        end
        else if (ce_in)
        begin
            rd_data_out <= rd_data_d;
            rd_valid_out <= rd_valid_d;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    AST_REF_ENABLE: assert property (
        ce_in && wr_en_in && addr_in == ADDR_OUTPUT_CONTROL
        |=> ref_enable_out == $past(wr_data_in[REF_ENABLE_BIT]))
        else $error("reference enable did not follow write");
    AST_EDGE_RATE: assert property (
        ce_in && wr_en_in && addr_in == ADDR_OUTPUT_CONTROL
        |=> ref_edge_rate_out == $past(wr_data_in[4:3]))
        else $error("edge rate did not follow write");
    AST_STOPPABLE: assert property (
        ce_in && !halt_n_s && stop_sel_q[2]
        |=> !proc_out_enable_out[0])
        else $error("stoppable output 0 not stopped");
    AST_FREE_RUN: assert property (
        ce_in && stop_sel_q == 3'h0 |=> proc_out_enable_out == 3'h7)
        else $error("free-running output was stopped");
    AST_DIV_LOW: assert property (
        ce_in && wr_en_in && addr_in == ADDR_CPU_DIVIDER_LOW
        |=> proc_divider_out[7:0] == $past(wr_data_in) && $stable(proc_divider_out[8]))
        else $error("divider low byte wrong");
    AST_DIV_HIGH_READ: assert property (
        ce_in && rd_en_in && addr_in == ADDR_CPU_DIVIDER_HIGH
        |=> rd_valid_out && rd_data_out == {7'h7f, $past(proc_divider_out[8])})
        else $error("byte 4 readback wrong");
    AST_PANEL: assert property (
        ce_in && rd_en_in && addr_in == ADDR_PANEL_DIVIDER_READBACK
        |=> rd_data_out == $past(panel_divider_in[7:0]))
        else $error("panel divider readback wrong");
    AST_STRAP_HELD: assert property (
        strap_st_q == ST_HOLD |=> $stable(strap_q) && strap_st_q == ST_HOLD)
        else $error("latched straps changed");
    AST_REQ_LIVE: assert property (
        ce_in && rd_en_in && addr_in == ADDR_STRAP_AND_REQUEST_STATUS
        |=> rd_data_out[5:3] == {$past(req_s[0]), $past(req_s[1]), $past(req_s[2])}
        && rd_data_out[2:0] == 3'h0)
        else $error("request readback wrong");
    AST_RSVD_SIX: assert property (
        ce_in && rd_en_in && addr_in == ADDR_RESERVED_SIX |=> rd_data_out == 8'hc3)
        else $error("byte 6 readback wrong");

    COV_WRITE_CTRL: cover property (ce_in && wr_en_in && addr_in == ADDR_OUTPUT_CONTROL);
    COV_READ_STATUS: cover property (rd_valid_out ##1 strap_st_q == ST_HOLD);
    COV_HALT_STOP: cover property (proc_out_enable_out != 3'h7);
endmodule
`default_nettype wire

//--- verification/cgcs_host.sv
// host-side model issuing byte writes and reads on the register port
`timescale 1ns/1ps
`default_nettype none
module cgcs_host (
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    output logic [7:0] addr_out,
    output logic wr_en_out,
    output logic [7:0] wr_data_out,
    output logic rd_en_out
);
    initial
    begin
        addr_out = 8'h00;
        wr_en_out = 1'b0;
        wr_data_out = 8'h00;
        rd_en_out = 1'b0;
    end

    // released address and data lines flip so a stale value never looks like a held one; the enables drop to 0
    task automatic release_bus();
        addr_out = ~addr_out;
        wr_data_out = ~wr_data_out;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
    endtask

    // edge-rate code 11 is never sent from here
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        addr_out = addr;
        wr_data_out = data;
        wr_en_out = 1'b1;
        @(negedge clk_in);
        release_bus();
    endtask

    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        @(negedge clk_in);
        addr_out = addr;
        rd_en_out = 1'b1;
        @(negedge clk_in);
        data = rd_data_in;
        valid = rd_valid_in;
        release_bus();
    endtask
endmodule
`default_nettype wire

//--- verification/clock_gen_ctrl_status_bytes_bench.sv
// self-checking bench for the control and status byte bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
            error_cnt++; \
        end \
    end
module clock_gen_ctrl_status_bytes_bench;
    import cgcs_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } cgcs_row_s;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ce_in = 1'b1;
    logic [7:0] addr, wr_data, rd_data;
    logic wr_en, rd_en, rd_valid, halt_n = 1'b1, freq_select_b = 1'b1, freq_select_c = 1'b0;
    logic [2:0] req_n = 3'b101;
    logic [8:0] panel_div = 9'h15a;
    logic ref_en;
    logic [1:0] edge_rate;
    logic [2:0] proc_en;
    logic [8:0] proc_div;
    int error_cnt = 0;
    int n_compared = 0;
    // data field of a read row holds the expected byte
    cgcs_row_s rows [0:23] = '{
        '{0, 8'h03, 8'h30}, '{0, 8'h04, 8'hfe}, '{0, 8'h05, 8'h00}, '{0, 8'h06, 8'hc3},
        '{0, 8'h07, 8'h00}, '{0, 8'h08, 8'h80}, '{0, 8'h09, 8'h5a}, '{0, 8'h0a, 8'ha8},
        '{1, 8'h04, 8'h00}, '{0, 8'h04, 8'hfe}, '{1, 8'h04, 8'hff}, '{0, 8'h04, 8'hff},
        '{1, 8'h05, 8'ha5}, '{0, 8'h05, 8'ha5}, '{1, 8'h06, 8'h00}, '{0, 8'h06, 8'hc3},
        '{1, 8'h07, 8'hff}, '{0, 8'h07, 8'h00}, '{1, 8'h08, 8'h7f}, '{0, 8'h08, 8'h80},
        '{1, 8'h0a, 8'h00}, '{0, 8'h0a, 8'ha8}, '{1, 8'h03, 8'he7}, '{0, 8'h03, 8'h27}
    };

    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end

    cgcs_host HOST (.clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
        .addr_out(addr), .wr_en_out(wr_en), .wr_data_out(wr_data), .rd_en_out(rd_en));

    cgcs_regs DUT (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr),
        .wr_en_in(wr_en), .wr_data_in(wr_data), .rd_en_in(rd_en), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .proc_clock_halt_n_in(halt_n),
        .clock_request_0_n_in(req_n[0]), .clock_request_1_n_in(req_n[1]),
        .clock_request_2_n_in(req_n[2]), .freq_select_b_in(freq_select_b), .freq_select_c_in(freq_select_c),
        .panel_divider_in(panel_div), .ref_enable_out(ref_en), .ref_edge_rate_out(edge_rate),
        .proc_out_enable_out(proc_en), .proc_divider_out(proc_div));

    task automatic test_done();
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        HOST.read_byte(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, exp)
    endtask

    task automatic settle();
        repeat (8) @(negedge clk_in);
    endtask

    initial
    begin
        #20000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        repeat (8) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (12) @(negedge clk_in);
        for (int i = 0; i < 24; i++)
        begin
            if (rows[i].wr)
                HOST.write_byte(rows[i].addr, rows[i].data);
            else
                rd_chk(rows[i].addr, rows[i].data);
        end
        rd_chk(8'h0b, 8'h00);
        `CHK(proc_div, 9'h1a5)
        `CHK(proc_en, 3'b111)
        for (int c = 0; c < 3; c++)
        begin
            HOST.write_byte(8'h03, {3'b000, c[1:0], 3'b000});
            `CHK(edge_rate, c[1:0])
            `CHK(ref_en, 1'b0)
        end
        // clock 0 follows bit 2, clock 2 follows bit 0
        HOST.write_byte(8'h03, 8'h24);
        `CHK(ref_en, 1'b1)
        halt_n = 1'b0;
        settle();
        `CHK(proc_en, 3'b110)
        HOST.write_byte(8'h03, 8'h21);
        @(negedge clk_in);
        `CHK(proc_en, 3'b011)
        halt_n = 1'b1;
        settle();
        `CHK(proc_en, 3'b111)
        req_n = 3'b011;
        freq_select_b = 1'b0;
        freq_select_c = 1'b1;
        settle();
        rd_chk(8'h0a, 8'hb0);
        // stalled clock enable drops the write
        ce_in = 1'b0;
        HOST.write_byte(8'h05, 8'h11);
        ce_in = 1'b1;
        rd_chk(8'h05, 8'ha5);
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK({ref_en, edge_rate, proc_en}, 6'b110111)
        `CHK(proc_div, 9'h000)
        rstn_in = 1'b1;
        repeat (12) @(negedge clk_in);
        rd_chk(8'h03, 8'h30);
        rd_chk(8'h0a, 8'h70);
        test_done();
    end
endmodule
`default_nettype wire
